// ===== scanner_status_telegram_packer.sv
/*
  Packs telegram bytes 4 to 15 of the scanner status: connector lines,
  scan sequence count, and protective function A status, selection and
  segment bits. Offers the result as a parallel frame and a byte stream.
  Assumes all status inputs are synchronous to clk and settled when
  scan_done pulses, and that rst_n is asserted only at power-up.
*/
// Functional notes
// - Bytes 8 to 11 hold a 32-bit scan count, plus one per scan.
// - The scan count clears only at the power-up reset; it otherwise keeps running.
// - Byte 12 bit 7 is one while function A is configured and active.
// - Byte 12 bit 6 is the active warning field: zero violated, one free.
// - Byte 12 bit 5 is the active guard field: zero violated, one free.
// - Byte 12 bit 3 mirrors the internal switch signal of output pair A.
// - Byte 13 holds bank number high and first field pair low, 1 to 10.
// - Byte 14 holds second field pair high and third low, 1 to 10.
// - Byte 15 bits 7 and 6 are warning segments 1 and 2, one free.
// - Byte 15 bits 5 and 4 are guard segments 1 and 2, one free.
// - Byte 15 bits 3 and 2 flag each defined field pair being selected.
`timescale 1ns/1ps
`default_nettype none
module scanner_status_telegram_packer
  import scanner_tlg_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             scan_done,
  input  wire logic [9:0]       control_in,
  input  wire logic [1:0]       start_in,
  input  wire logic [3:0]       edm_in,
  input  wire logic [1:0]       linkage_in,
  input  wire logic             pnp_select,
  input  wire logic [4:0]       output_state,
  input  wire logic             func_a_active,
  input  wire logic             func_a_warn_field_free,
  input  wire logic             func_a_guard_field_free,
  input  wire logic             func_a_restart_lock,
  input  wire logic             safety_switch_output,
  input  wire logic [3:0]       func_a_bank_sel,
  input  wire logic [3:0]       func_a_pair_sel1,
  input  wire logic [3:0]       func_a_pair_sel2,
  input  wire logic [3:0]       func_a_pair_sel3,
  input  wire logic             func_a_warn_seg1_free,
  input  wire logic             func_a_warn_seg2_free,
  input  wire logic             func_a_guard_seg1_free,
  input  wire logic             func_a_guard_seg2_free,
  input  wire logic             func_a_defined_pair1_chosen,
  input  wire logic             func_a_defined_pair2_chosen,
  output var  tlg_frame_t       frame,
  output var  logic             frame_valid,
  output var  logic [31:0]      scan_count,
  output var  tlg_byte_t        byte_data,
  output var  logic             byte_valid,
  output var  logic [IDX_W-1:0] byte_index,
  output var  logic             byte_last
);

  tlg_stream_if stream ();

  logic [SCAN_CNT_W-1:0] scan_cnt_reg;
  logic [SCAN_CNT_W-1:0] scan_cnt_next;
  tlg_frame_t            frame_reg;
  tlg_frame_t            frame_next;
  logic                  load_reg;
  tlg_byte_t             bytes [FIRST_BYTE:LAST_BYTE];

  // Out-of-range selections are shown as the default zero so the host
  // never sees a bank or pair number that cannot exist.
  function automatic logic [3:0] legal_nibble(input logic [3:0] value);
    if (value >= NIBBLE_MIN && value <= NIBBLE_MAX) begin
      return value;
    end
    return NIBBLE_RESET;
  endfunction

  // The count wraps after 2^32 scans; with scans tens of milliseconds
  // apart this is years of uptime, so no saturation is added.
  assign scan_cnt_next = scan_cnt_reg + SCAN_CNT_STEP;

  // Only the power-up reset clears the count; nothing else touches it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_cnt_reg <= SCAN_CNT_RESET;
    end else if (scan_done) begin
      scan_cnt_reg <= scan_cnt_next;
    end
  end

  always_comb begin
    bytes[BYTE_IN_A] = {control_in[0], control_in[1], control_in[2],
                        control_in[3], control_in[4], control_in[5],
                        control_in[6], control_in[7]};
    bytes[BYTE_IN_B] = {control_in[8], control_in[9], start_in[0],
                        start_in[1], edm_in[0], edm_in[1], edm_in[2],
                        edm_in[3]};
    bytes[BYTE_IN_C] = {linkage_in[0], linkage_in[1], pnp_select,
                        output_state[0], output_state[1],
                        output_state[2], output_state[3],
                        output_state[4]};
    bytes[BYTE_RSVD] = BYTE_ZERO;
    // The telegram carries the count including the scan just finished.
    bytes[BYTE_CNT_HI]     = scan_cnt_next[31:24];
    bytes[BYTE_CNT_HI + 1] = scan_cnt_next[23:16];
    bytes[BYTE_CNT_HI + 2] = scan_cnt_next[15:8];
    bytes[BYTE_CNT_HI + 3] = scan_cnt_next[7:0];
    bytes[BYTE_FUNC_A] = BYTE_ZERO;
    bytes[BYTE_FUNC_A][ACTIVE_BIT]  = func_a_active;
    bytes[BYTE_FUNC_A][WARN_BIT]    = func_a_warn_field_free;
    bytes[BYTE_FUNC_A][GUARD_BIT]   = func_a_guard_field_free;
    bytes[BYTE_FUNC_A][RESTART_BIT] = func_a_restart_lock;
    bytes[BYTE_FUNC_A][SWITCH_BIT]  = safety_switch_output;
    bytes[BYTE_SEL_A] = {legal_nibble(func_a_bank_sel),
                         legal_nibble(func_a_pair_sel1)};
    bytes[BYTE_SEL_B] = {legal_nibble(func_a_pair_sel2),
                         legal_nibble(func_a_pair_sel3)};
    bytes[BYTE_SEG] = BYTE_ZERO;
    bytes[BYTE_SEG][WSEG1_BIT] = func_a_warn_seg1_free;
    bytes[BYTE_SEG][WSEG2_BIT] = func_a_warn_seg2_free;
    bytes[BYTE_SEG][GSEG1_BIT] = func_a_guard_seg1_free;
    bytes[BYTE_SEG][GSEG2_BIT] = func_a_guard_seg2_free;
    bytes[BYTE_SEG][PAIR1_BIT] = func_a_defined_pair1_chosen;
    bytes[BYTE_SEG][PAIR2_BIT] = func_a_defined_pair2_chosen;
  end

  // Byte 4 lands in the top lane so the frame reads in telegram order.
  genvar gi;
  generate
    for (gi = FIRST_BYTE; gi <= LAST_BYTE; gi++) begin : g_pack
      assign frame_next[FRAME_W-1-8*(gi-FIRST_BYTE) -: 8] = bytes[gi];
    end
  endgenerate

  // The frame is a snapshot: it changes only at scan_done, so a reader
  // never sees a telegram mixing two scans.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= '0;
      load_reg  <= 1'b0;
    end else begin
      load_reg <= scan_done;
      if (scan_done) begin
        frame_reg <= frame_next;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame       <= '0;
      frame_valid <= 1'b0;
      scan_count  <= SCAN_CNT_RESET;
    end else begin
      frame       <= frame_reg;
      frame_valid <= load_reg;
      scan_count  <= scan_cnt_reg;
    end
  end

  assign stream.frame = frame_reg;
  assign stream.load  = load_reg;

  tlg_serializer u_serializer (
    .clk        (clk),
    .rst_n      (rst_n),
    .link       (stream.sink),
    .byte_data  (byte_data),
    .byte_valid (byte_valid),
    .byte_index (byte_index),
    .byte_last  (byte_last)
  );

endmodule
`default_nettype wire

// ===== scanner_tlg_pkg.sv
/*
  Constants and types for the status telegram packer: byte positions,
  bit positions inside each byte, field widths and reset values.
  Assumes every user of it imports the whole package.
*/
`default_nettype none
package scanner_tlg_pkg;

  // Telegram span handled here: bytes 4 to 15.
  localparam int FIRST_BYTE = 4;
  localparam int LAST_BYTE  = 15;
  localparam int NUM_BYTES  = LAST_BYTE - FIRST_BYTE + 1;
  localparam int FRAME_W    = NUM_BYTES * 8;
  localparam int IDX_W      = 4;

  // Byte numbers of the individual groups.
  localparam int BYTE_IN_A    = 4;
  localparam int BYTE_IN_B    = 5;
  localparam int BYTE_IN_C    = 6;
  localparam int BYTE_RSVD    = 7;
  localparam int BYTE_CNT_HI  = 8;
  localparam int BYTE_FUNC_A  = 12;
  localparam int BYTE_SEL_A   = 13;
  localparam int BYTE_SEL_B   = 14;
  localparam int BYTE_SEG     = 15;

  // Scan sequence count.
  localparam int          SCAN_CNT_W     = 32;
  localparam logic [31:0] SCAN_CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] SCAN_CNT_STEP  = 32'h0000_0001;

  // Byte 12 bit positions.
  localparam int ACTIVE_BIT  = 7;
  localparam int WARN_BIT    = 6;
  localparam int GUARD_BIT   = 5;
  localparam int RESTART_BIT = 4;
  localparam int SWITCH_BIT  = 3;

  // Byte 15 bit positions.
  localparam int WSEG1_BIT = 7;
  localparam int WSEG2_BIT = 6;
  localparam int GSEG1_BIT = 5;
  localparam int GSEG2_BIT = 4;
  localparam int PAIR1_BIT = 3;
  localparam int PAIR2_BIT = 2;

  // Selection nibbles: legal values 1 to 10, default 0.
  localparam int         NIBBLE_W     = 4;
  localparam logic [3:0] NIBBLE_MIN   = 4'h1;
  localparam logic [3:0] NIBBLE_MAX   = 4'hA;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef logic [7:0] tlg_byte_t;
  typedef logic [FRAME_W-1:0] tlg_frame_t;

endpackage
`default_nettype wire

// ===== tlg_stream_if.sv
/*
  Carrier between the packer and its byte serialiser: a frame snapshot
  with a one-cycle load strobe, and the serialiser's busy level back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface tlg_stream_if;
  import scanner_tlg_pkg::*;
  tlg_frame_t frame;
  logic       load;
  logic       busy;
  modport source (output frame, output load, input busy);
  modport sink   (input frame, input load, output busy);
endinterface
`default_nettype wire

// ===== tlg_serializer.sv
/*
  Sends a loaded frame out one byte per clock, byte 4 first.
  Assumes a load never comes faster than one frame in thirteen cycles; a
  load during a send restarts with the newer frame.
*/
`timescale 1ns/1ps
`default_nettype none
module tlg_serializer
  import scanner_tlg_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  tlg_stream_if.sink            link,
  output var  tlg_byte_t        byte_data,
  output var  logic             byte_valid,
  output var  logic [IDX_W-1:0] byte_index,
  output var  logic             byte_last
);

  typedef enum {ST_IDLE, ST_SEND} ser_state_t;

  ser_state_t       state_reg;
  tlg_frame_t       shift_reg;
  logic [IDX_W-1:0] count_reg;

  localparam logic [IDX_W-1:0] FIRST_IDX = IDX_W'(FIRST_BYTE);
  localparam logic [IDX_W-1:0] LAST_IDX  = IDX_W'(LAST_BYTE);

  assign link.busy = (state_reg == ST_SEND);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= '0;
      count_reg <= '0;
    end else if (link.load) begin
      state_reg <= ST_SEND;
      shift_reg <= link.frame;
      count_reg <= FIRST_IDX;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          count_reg <= count_reg;
        end
        ST_SEND: begin
          shift_reg <= {shift_reg[FRAME_W-9:0], BYTE_ZERO};
          count_reg <= count_reg + 4'h1;
          if (count_reg == LAST_IDX) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_data  <= BYTE_ZERO;
      byte_valid <= 1'b0;
      byte_index <= '0;
      byte_last  <= 1'b0;
    end else begin
      byte_valid <= (state_reg == ST_SEND) && !link.load;
      byte_data  <= (state_reg == ST_SEND) ? shift_reg[FRAME_W-1 -: 8]
                                           : BYTE_ZERO;
      byte_index <= count_reg;
      byte_last  <= (state_reg == ST_SEND) && !link.load &&
                    (count_reg == LAST_IDX);
    end
  end

endmodule
`default_nettype wire

// ===== scanner_status_telegram_packer_asserts.sv
/*
  Checker for the status telegram packer: count, frame timing and bits.
  Assumes it is bound to the packer top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module scanner_status_telegram_packer_asserts
  import scanner_tlg_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        scan_done,
  input wire logic        func_a_active,
  input wire logic        func_a_warn_field_free,
  input wire logic        func_a_guard_field_free,
  input wire logic        safety_switch_output,
  input wire logic        func_a_warn_seg1_free,
  input wire logic        func_a_warn_seg2_free,
  input wire logic        func_a_guard_seg1_free,
  input wire logic        func_a_guard_seg2_free,
  input wire logic        func_a_defined_pair1_chosen,
  input wire logic        func_a_defined_pair2_chosen,
  input wire tlg_frame_t  frame,
  input wire logic        frame_valid,
  input wire logic [31:0] scan_count,
  input wire logic [3:0]  byte_index,
  input wire logic        byte_last
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // The count output is registered once more after the pulse edge, so a
  // pulse shows up in scan_count two edges later.
  a_count_step: assert property (
    scan_done |-> ##2 scan_count == $past(scan_count) + 32'h1)
    else $error("scan count did not step by one");
  a_count_hold: assert property (
    !scan_done |-> ##2 $stable(scan_count)) else $error("scan count moved");
  a_frame_due: assert property (scan_done |-> ##2 frame_valid)
    else $error("frame not offered in time");
  a_frame_count: assert property (
    frame_valid |-> frame[63:32] == scan_count)
    else $error("frame count differs from scan count");
  a_func_bits: assert property (
    frame_valid |-> {frame[31:29], frame[27]} == $past({func_a_active,
    func_a_warn_field_free, func_a_guard_field_free,
    safety_switch_output}, 2)) else $error("function bits wrong");
  a_seg_bits: assert property (
    frame_valid |-> frame[7:2] == $past({func_a_warn_seg1_free,
    func_a_warn_seg2_free, func_a_guard_seg1_free, func_a_guard_seg2_free,
    func_a_defined_pair1_chosen, func_a_defined_pair2_chosen}, 2))
    else $error("segment bits wrong");
  a_reserved_zero: assert property (
    frame_valid |-> frame[71:64] == 8'h00 && frame[26:24] == 3'h0 &&
    frame[1:0] == 2'h0) else $error("reserved bits not zero");
  a_last_byte: assert property (
    byte_last |-> byte_index == 4'hF && $past(byte_index) == 4'hE)
    else $error("last byte out of order");
  a_sel_range: assert property (
    frame_valid |-> frame[23:20] <= NIBBLE_MAX && frame[19:16] <= NIBBLE_MAX
    && frame[15:12] <= NIBBLE_MAX && frame[11:8] <= NIBBLE_MAX)
    else $error("selection nibble out of range");
endmodule
bind scanner_status_telegram_packer scanner_status_telegram_packer_asserts
  i_chk (.clk(clk), .rst_n(rst_n), .scan_done(scan_done),
  .func_a_active(func_a_active),
  .func_a_warn_field_free(func_a_warn_field_free),
  .func_a_guard_field_free(func_a_guard_field_free),
  .safety_switch_output(safety_switch_output),
  .func_a_warn_seg1_free(func_a_warn_seg1_free),
  .func_a_warn_seg2_free(func_a_warn_seg2_free),
  .func_a_guard_seg1_free(func_a_guard_seg1_free),
  .func_a_guard_seg2_free(func_a_guard_seg2_free),
  .func_a_defined_pair1_chosen(func_a_defined_pair1_chosen),
  .func_a_defined_pair2_chosen(func_a_defined_pair2_chosen),
  .frame(frame), .frame_valid(frame_valid), .scan_count(scan_count),
  .byte_index(byte_index), .byte_last(byte_last));
`default_nettype wire

// ===== tlg_reader.sv
/*
  Reader model: rebuilds the telegram from the byte stream.
  Assumes the stream shares the packer's clock and never stalls.
*/
`timescale 1ns/1ps
`default_nettype none
module tlg_reader
  import scanner_tlg_pkg::*;
(
  input  wire logic             clk,
  input  wire tlg_byte_t        byte_data,
  input  wire logic             byte_valid,
  input  wire logic [IDX_W-1:0] byte_index,
  input  wire logic             byte_last,
  output var  tlg_frame_t       rx_frame,
  output var  logic             rx_done
);
  initial rx_done = 1'b0;
  // A restarted burst clears done, so only complete frames count.
  always @(posedge clk) begin
    if (byte_valid) begin
      rx_frame[8*(LAST_BYTE-byte_index) +: 8] <= byte_data;
      rx_done <= byte_last;
    end
  end
endmodule
`default_nettype wire

// ===== scanner_status_telegram_packer_bench.sv
/*
  Self-checking bench for the status telegram packer and its stream.
  Assumes the bound checker and the reader model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module scanner_status_telegram_packer_bench;
  import scanner_tlg_pkg::*;
  logic clk, rst_n, scan_done, pnp, fa, fw, fg, fr, fs, fv, bv, bl, rd;
  logic [9:0] ctl;
  logic [1:0] st, lk;
  logic [3:0] edm, bk, p1, p2, p3, bi;
  logic [4:0] outs;
  logic [5:0] seg;
  logic [31:0] cnt, exp_cnt;
  tlg_frame_t fr_o, rx;
  tlg_byte_t bd;
  int bad_count, tests_run;
  scanner_status_telegram_packer i_dut (.clk(clk), .rst_n(rst_n),
    .scan_done(scan_done), .control_in(ctl), .start_in(st), .edm_in(edm),
    .linkage_in(lk), .pnp_select(pnp), .output_state(outs),
    .func_a_active(fa), .func_a_warn_field_free(fw),
    .func_a_guard_field_free(fg), .func_a_restart_lock(fr),
    .safety_switch_output(fs), .func_a_bank_sel(bk), .func_a_pair_sel1(p1),
    .func_a_pair_sel2(p2), .func_a_pair_sel3(p3),
    .func_a_warn_seg1_free(seg[5]), .func_a_warn_seg2_free(seg[4]),
    .func_a_guard_seg1_free(seg[3]), .func_a_guard_seg2_free(seg[2]),
    .func_a_defined_pair1_chosen(seg[1]),
    .func_a_defined_pair2_chosen(seg[0]), .frame(fr_o), .frame_valid(fv),
    .scan_count(cnt), .byte_data(bd), .byte_valid(bv), .byte_index(bi),
    .byte_last(bl));
  tlg_reader i_rd (.clk(clk), .byte_data(bd), .byte_valid(bv),
    .byte_index(bi), .byte_last(bl), .rx_frame(rx), .rx_done(rd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [3:0] nib(logic [3:0] v);
    return (v >= NIBBLE_MIN && v <= NIBBLE_MAX) ? v : NIBBLE_RESET;
  endfunction
  function automatic tlg_frame_t exp_frame(logic [31:0] c);
    tlg_byte_t b4;
    for (int i = 0; i < 8; i++) b4[7-i] = ctl[i];
    return {b4, ctl[8], ctl[9], st[0], st[1], edm[0], edm[1], edm[2],
      edm[3], lk[0], lk[1], pnp, outs[0], outs[1], outs[2], outs[3], outs[4],
      BYTE_ZERO, c, fa, fw, fg, fr, fs, 3'h0, nib(bk), nib(p1), nib(p2),
      nib(p3), seg, 2'h0};
  endfunction
  task automatic check(string what, logic [95:0] seen, logic [95:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic scan(logic [23:0] io, logic [4:0] f, logic [15:0] n,
                      logic [5:0] s, int pulses);
    @(negedge clk);
    {ctl, st, edm, lk, pnp, outs} = io;
    {fa, fw, fg, fr, fs} = f;
    {bk, p1, p2, p3} = n;
    seg = s;
    scan_done = 1'b1;
    exp_cnt += 32'(pulses);
    repeat (pulses) @(negedge clk);
    scan_done = 1'b0;
    // Count and frame both appear one edge after the last pulse edge.
    @(negedge clk);
    check("count", cnt, exp_cnt);
    check("frame_valid", fv, 1'b1);
    check("frame", fr_o, exp_frame(exp_cnt));
    @(negedge clk);
    check("frame_valid_drop", fv, 1'b0);
    // The last byte leaves eleven edges later; the reader needs one more.
    repeat (12) @(negedge clk);
    check("reader_done", rd, 1'b1);
    check("reader_frame", rx, exp_frame(exp_cnt));
  endtask
  task automatic power_cycle();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("reset_count", cnt, 32'h0);
    check("reset_frame", fr_o, 96'h0);
    rst_n = 1'b1;
    exp_cnt = 32'h0;
  endtask
  initial begin
    {rst_n, scan_done, ctl, st, edm, lk, pnp, outs} = '0;
    {fa, fw, fg, fr, fs, bk, p1, p2, p3, seg} = '0;
    exp_cnt = 32'h0;
    // Count rising edges so the start-up clock settling cannot shorten it.
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    scan(24'hA5C396, 5'h15, 16'h1A37, 6'h2D, 1);
    scan(24'h5A3C69, 5'h0A, 16'h2945, 6'h12, 1);
    // Sweep includes 0 and 11 to 15, which must read as zero.
    for (int v = 0; v < 16; v++) begin
      scan(24'hFFFFFF, 5'h1F, {4{4'(v)}}, 6'h3F, 1);
    end
    scan(24'h123456, 5'h11, 16'h5678, 6'h21, 2);
    power_cycle();
    scan(24'h0F0F0F, 5'h1B, 16'hA1A1, 6'h0C, 1);
    results();
  end
  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
